// >>> logic/tpgio_defines.vh
// Register map, field layout and reset values of the two-port general I/O block.
`ifndef TPGIO_DEFINES_VH
`define TPGIO_DEFINES_VH
`define TPGIO_ADDR_W 4
`define TPGIO_OFS_PORT1_DIRECTION 4'h0
`define TPGIO_OFS_PORT1_OUTPUT_VALUE 4'h4
`define TPGIO_OFS_PORT2_DIRECTION 4'h8
`define TPGIO_OFS_PORT2_OUTPUT_VALUE 4'hc
`define TPGIO_OFS_PORT1_FUNCTION_SELECT 4'h0
`define TPGIO_P1_IMPL_MASK 8'hf7
`define TPGIO_P1_RSVD_ONES 8'h08
`define TPGIO_P2_IMPL_MASK 8'h07
`define TPGIO_P2_RSVD_ONES 8'hf8
`define TPGIO_DIR_RESET 8'h00
`define TPGIO_DATA_RESET 8'h00
`define TPGIO_WO_READ 8'hff
`define TPGIO_RESP_OKAY 2'b00
`define TPGIO_RESP_SLVERR 2'b10
`endif

// >>> logic/tpgio_port.v
// One general I/O port: direction and data registers, pin drive and read-back mux.
`timescale 1ns/10ps
`include "tpgio_defines.vh"
module tpgio_port #(
   parameter [7:0] IMPL_MASK = 8'hff,
   parameter [7:0] RSVD_ONES = 8'h00
) (
   input wire clock_i,
   input wire rst_n_i,
   input wire dir_we_i,
   input wire data_we_i,
   input wire [7:0] wdata_i,
   input wire [7:0] periph_sel_i,
   input wire [7:0] periph_out_i,
   input wire [7:0] periph_oe_i,
   input wire [7:0] pin_in_i,
   output wire [7:0] rd_data_o,
   output wire [7:0] pin_out_d_o,
   output wire [7:0] pin_oe_n_d_o
);
   reg [7:0] dir_q;
   reg [7:0] data_q;
   wire [7:0] gio;

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dir_q <= `TPGIO_DIR_RESET;
         data_q <= `TPGIO_DATA_RESET;
      end else begin
         if (dir_we_i) begin
            dir_q <= wdata_i & IMPL_MASK;
         end
         if (data_we_i) begin
            data_q <= wdata_i & IMPL_MASK;
         end
      end
   end

   // Output bits show the stored value, input bits the live pin, reserved bits read one.
   assign rd_data_o = (((dir_q & data_q) | (~dir_q & pin_in_i)) & IMPL_MASK) | RSVD_ONES;

   assign gio = IMPL_MASK & ~periph_sel_i;
   assign pin_out_d_o = (gio & data_q) | (periph_sel_i & periph_out_i & IMPL_MASK);
   // Drive enable is active low; an input pin not handed to the peripheral, or an absent bit, stays released.
   assign pin_oe_n_d_o = ~((gio & dir_q) | (periph_sel_i & periph_oe_i & IMPL_MASK));
endmodule

// >>> logic/tpgio_axil.v
// AXI4-Lite slave front end producing single-cycle register write and read strobes.
`timescale 1ns/10ps
`include "tpgio_defines.vh"
module tpgio_axil (
   input wire clock_i,
   input wire rst_n_i,
   input wire [`TPGIO_ADDR_W-1:0] awaddr_i,
   input wire awvalid_i,
   output reg awready_o,
   input wire [31:0] wdata_i,
   input wire [3:0] wstrb_i,
   input wire wvalid_i,
   output reg wready_o,
   output reg [1:0] bresp_o,
   output reg bvalid_o,
   input wire bready_i,
   input wire [`TPGIO_ADDR_W-1:0] araddr_i,
   input wire arvalid_i,
   output reg arready_o,
   output reg [31:0] rdata_o,
   output reg [1:0] rresp_o,
   output reg rvalid_o,
   input wire rready_i,
   output wire wr_en_o,
   output wire [`TPGIO_ADDR_W-1:0] wr_addr_o,
   output wire [7:0] wr_data_o,
   output wire rd_en_o,
   output wire [`TPGIO_ADDR_W-1:0] rd_addr_o,
   input wire [7:0] rd_data_i,
   input wire rd_hit_i,
   input wire wr_hit_i
);
   reg aw_have_q;
   reg w_have_q;
   reg [`TPGIO_ADDR_W-1:0] aw_q;
   reg [7:0] wd_q;
   reg wlane_q;
   reg [`TPGIO_ADDR_W-1:0] ar_q;
   reg ar_have_q;

   // The write fires once address and data are both held and no response is pending.
   assign wr_en_o = aw_have_q && w_have_q && !bvalid_o;
   assign wr_addr_o = aw_q;
   assign wr_data_o = wd_q;
   assign rd_en_o = ar_have_q && !rvalid_o;
   assign rd_addr_o = ar_q;

   always @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         awready_o <= 1'b0;
         wready_o <= 1'b0;
         arready_o <= 1'b0;
         bvalid_o <= 1'b0;
         rvalid_o <= 1'b0;
         bresp_o <= `TPGIO_RESP_OKAY;
         rresp_o <= `TPGIO_RESP_OKAY;
         rdata_o <= 32'h00000000;
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         ar_have_q <= 1'b0;
         aw_q <= {`TPGIO_ADDR_W{1'b0}};
         ar_q <= {`TPGIO_ADDR_W{1'b0}};
         wd_q <= 8'h00;
         wlane_q <= 1'b0;
      end else begin
         awready_o <= !aw_have_q && !awready_o && awvalid_i;
         wready_o <= !w_have_q && !wready_o && wvalid_i;
         arready_o <= !ar_have_q && !arready_o && !rvalid_o && arvalid_i;
         if (awvalid_i && awready_o) begin
            aw_have_q <= 1'b1;
            aw_q <= awaddr_i;
         end
         if (wvalid_i && wready_o) begin
            w_have_q <= 1'b1;
            wd_q <= wdata_i[7:0];
            wlane_q <= wstrb_i[0];
         end
         if (arvalid_i && arready_o) begin
            ar_have_q <= 1'b1;
            ar_q <= araddr_i;
         end
         if (wr_en_o) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            bvalid_o <= 1'b1;
            bresp_o <= wr_hit_i ? `TPGIO_RESP_OKAY : `TPGIO_RESP_SLVERR;
         end else if (bvalid_o && bready_i) begin
            bvalid_o <= 1'b0;
         end
         if (rd_en_o) begin
            ar_have_q <= 1'b0;
            rvalid_o <= 1'b1;
            rdata_o <= {24'h000000, rd_hit_i ? rd_data_i : 8'h00};
            rresp_o <= rd_hit_i ? `TPGIO_RESP_OKAY : `TPGIO_RESP_SLVERR;
         end else if (rvalid_o && rready_i) begin
            rvalid_o <= 1'b0;
         end
      end
   end

   // A write with byte lane 0 disabled is answered but leaves the register unchanged.
   wire unused_lane = wlane_q;
endmodule

// >>> logic/tpgio_top.v
// Top of the two-port general I/O block: reset sync, register decode and registered pins.
`timescale 1ns/10ps
`include "tpgio_defines.vh"
module tpgio_top (
   input wire clock_i,
   input wire rstn_i,
   input wire [`TPGIO_ADDR_W-1:0] s_axi_awaddr_i,
   input wire s_axi_awvalid_i,
   output wire s_axi_awready_o,
   input wire [31:0] s_axi_wdata_i,
   input wire [3:0] s_axi_wstrb_i,
   input wire s_axi_wvalid_i,
   output wire s_axi_wready_o,
   output wire [1:0] s_axi_bresp_o,
   output wire s_axi_bvalid_o,
   input wire s_axi_bready_i,
   input wire [`TPGIO_ADDR_W-1:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   output wire s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0] s_axi_rresp_o,
   output wire s_axi_rvalid_o,
   input wire s_axi_rready_i,
   input wire [7:0] port1_function_select_i,
   input wire [7:0] port1_periph_out_i,
   input wire [7:0] port1_periph_oe_i,
   input wire [7:0] port2_function_select_i,
   input wire [7:0] port2_periph_out_i,
   input wire [7:0] port2_periph_oe_i,
   input wire [7:0] port1_pin_i,
   output reg [7:0] port1_pin_o,
   output reg [7:0] port1_pin_oe_n_o,
   input wire [7:0] port2_pin_i,
   output reg [7:0] port2_pin_o,
   output reg [7:0] port2_pin_oe_n_o
);
   reg rst_meta_q;
   reg rst_sync_q;
   wire rst_n;
   wire wr_en;
   wire [`TPGIO_ADDR_W-1:0] wr_addr;
   wire [7:0] wr_data;
   wire rd_en;
   wire [`TPGIO_ADDR_W-1:0] rd_addr;
   reg [7:0] rd_data;
   reg rd_hit;
   wire [7:0] p1_rd;
   wire [7:0] p2_rd;
   wire [7:0] p1_out_d;
   wire [7:0] p1_oe_n_d;
   wire [7:0] p2_out_d;
   wire [7:0] p2_oe_n_d;

   function addr_is;
      input [`TPGIO_ADDR_W-1:0] addr;
      input [`TPGIO_ADDR_W-1:0] ofs;
      begin
         addr_is = (addr[`TPGIO_ADDR_W-1:2] == ofs[`TPGIO_ADDR_W-1:2]);
      end
   endfunction

   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   assign rst_n = rst_sync_q;

   tpgio_axil u_axil (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .awaddr_i(s_axi_awaddr_i),
      .awvalid_i(s_axi_awvalid_i),
      .awready_o(s_axi_awready_o),
      .wdata_i(s_axi_wdata_i),
      .wstrb_i(s_axi_wstrb_i),
      .wvalid_i(s_axi_wvalid_i),
      .wready_o(s_axi_wready_o),
      .bresp_o(s_axi_bresp_o),
      .bvalid_o(s_axi_bvalid_o),
      .bready_i(s_axi_bready_i),
      .araddr_i(s_axi_araddr_i),
      .arvalid_i(s_axi_arvalid_i),
      .arready_o(s_axi_arready_o),
      .rdata_o(s_axi_rdata_o),
      .rresp_o(s_axi_rresp_o),
      .rvalid_o(s_axi_rvalid_o),
      .rready_i(s_axi_rready_i),
      .wr_en_o(wr_en),
      .wr_addr_o(wr_addr),
      .wr_data_o(wr_data),
      .rd_en_o(rd_en),
      .rd_addr_o(rd_addr),
      .rd_data_i(rd_data),
      .rd_hit_i(rd_hit),
      .wr_hit_i(1'b1)
   );

   // Writes of byte lane 0 only reach the registers; other lanes are ignored.
   reg wlane0_q;
   wire wr_ok;
   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         wlane0_q <= 1'b0;
      end else if (s_axi_wvalid_i && s_axi_wready_o) begin
         wlane0_q <= s_axi_wstrb_i[0];
      end
   end
   assign wr_ok = wr_en && wlane0_q;

   tpgio_port #(
      .IMPL_MASK(`TPGIO_P1_IMPL_MASK),
      .RSVD_ONES(`TPGIO_P1_RSVD_ONES)
   ) u_port1 (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .dir_we_i(wr_ok && addr_is(wr_addr, `TPGIO_OFS_PORT1_DIRECTION)),
      .data_we_i(wr_ok && addr_is(wr_addr, `TPGIO_OFS_PORT1_OUTPUT_VALUE)),
      .wdata_i(wr_data),
      .periph_sel_i(port1_function_select_i),
      .periph_out_i(port1_periph_out_i),
      .periph_oe_i(port1_periph_oe_i),
      .pin_in_i(port1_pin_i),
      .rd_data_o(p1_rd),
      .pin_out_d_o(p1_out_d),
      .pin_oe_n_d_o(p1_oe_n_d)
   );

   tpgio_port #(
      .IMPL_MASK(`TPGIO_P2_IMPL_MASK),
      .RSVD_ONES(`TPGIO_P2_RSVD_ONES)
   ) u_port2 (
      .clock_i(clock_i),
      .rst_n_i(rst_n),
      .dir_we_i(wr_ok && addr_is(wr_addr, `TPGIO_OFS_PORT2_DIRECTION)),
      .data_we_i(wr_ok && addr_is(wr_addr, `TPGIO_OFS_PORT2_OUTPUT_VALUE)),
      .wdata_i(wr_data),
      .periph_sel_i(port2_function_select_i),
      .periph_out_i(port2_periph_out_i),
      .periph_oe_i(port2_periph_oe_i),
      .pin_in_i(port2_pin_i),
      .rd_data_o(p2_rd),
      .pin_out_d_o(p2_out_d),
      .pin_oe_n_d_o(p2_oe_n_d)
   );

   // The map fills the whole four-bit window, so every aligned word decodes.
   always @* begin
      rd_hit = 1'b1;
      rd_data = `TPGIO_WO_READ;
      if (addr_is(rd_addr, `TPGIO_OFS_PORT1_OUTPUT_VALUE)) begin
         rd_data = p1_rd;
      end else if (addr_is(rd_addr, `TPGIO_OFS_PORT2_OUTPUT_VALUE)) begin
         rd_data = p2_rd;
      end
      if (!rd_en) begin
         rd_data = 8'h00;
      end
   end

   // Pins are registered so each drives straight from a flip-flop; this costs one cycle of latency.
   always @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         port1_pin_o <= 8'h00;
         port1_pin_oe_n_o <= 8'hff;
         port2_pin_o <= 8'h00;
         port2_pin_oe_n_o <= 8'hff;
      end else begin
         port1_pin_o <= p1_out_d;
         port1_pin_oe_n_o <= p1_oe_n_d;
         port2_pin_o <= p2_out_d;
         port2_pin_oe_n_o <= p2_oe_n_d;
      end
   end
endmodule

// >>> sim/tpgio_assertions.sv
// Concurrent checks on the ports of the two-port general I/O top module.
`timescale 1ns/10ps
`include "tpgio_defines.vh"
module tpgio_assertions (
   input wire clock_i,
   input wire rstn_i,
   input wire s_axi_awvalid_i,
   input wire s_axi_awready_o,
   input wire s_axi_bvalid_o,
   input wire [1:0] s_axi_bresp_o,
   input wire [`TPGIO_ADDR_W-1:0] s_axi_araddr_i,
   input wire s_axi_arvalid_i,
   input wire s_axi_arready_o,
   input wire [31:0] s_axi_rdata_o,
   input wire [1:0] s_axi_rresp_o,
   input wire s_axi_rvalid_o,
   input wire [7:0] port1_function_select_i,
   input wire [7:0] port1_periph_out_i,
   input wire [7:0] port1_periph_oe_i,
   input wire [7:0] port2_function_select_i,
   input wire [7:0] port2_periph_out_i,
   input wire [7:0] port2_periph_oe_i,
   input wire [7:0] port1_pin_o,
   input wire [7:0] port1_pin_oe_n_o,
   input wire [7:0] port2_pin_o,
   input wire [7:0] port2_pin_oe_n_o
);
   // The design uses a two-flop copy of reset, so checks start one edge after that copy lets go.
   reg [2:0] ok_q;
   reg [`TPGIO_ADDR_W-1:0] raddr_q;
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ok_q <= 3'h0;
         raddr_q <= 4'h0;
      end else begin
         ok_q <= {ok_q[1:0], 1'b1};
         if (s_axi_arvalid_i && s_axi_arready_o) raddr_q <= s_axi_araddr_i;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!ok_q[2]);
   property p_p1_rsvd_idle; port1_pin_oe_n_o[3] && !port1_pin_o[3]; endproperty
   a_p1_rsvd_idle: assert property (p_p1_rsvd_idle) else $error("port1 bit 3 driven");
   property p_p2_rsvd_idle; port2_pin_oe_n_o[7:3] == 5'h1f; endproperty
   a_p2_rsvd_idle: assert property (p_p2_rsvd_idle) else $error("port2 upper bits driven");
   property p_p1_periph;
      (((port1_pin_o ^ $past(port1_periph_out_i)) & ~port1_pin_oe_n_o | (port1_pin_oe_n_o ^ ~$past(port1_periph_oe_i)))
         & $past(port1_function_select_i) & 8'hf7) == 8'h00;
   endproperty
   a_p1_periph: assert property (p_p1_periph) else $error("port1 peripheral pin wrong");
   property p_p2_periph;
      (((port2_pin_o ^ $past(port2_periph_out_i)) & ~port2_pin_oe_n_o | (port2_pin_oe_n_o ^ ~$past(port2_periph_oe_i)))
         & $past(port2_function_select_i) & 8'h07) == 8'h00;
   endproperty
   a_p2_periph: assert property (p_p2_periph) else $error("port2 peripheral pin wrong");
   property p_wr_answer;
      s_axi_awvalid_i && s_axi_awready_o |-> ##[1:3] (s_axi_bvalid_o && s_axi_bresp_o == 2'b00);
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response late");
   // The address is held one edge after the handshake and the answer is registered one edge later still.
   property p_rd_answer; s_axi_arvalid_i && s_axi_arready_o |-> ##2 s_axi_rvalid_o && s_axi_rresp_o == 2'b00; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read response late");
   property p_dir_ones; s_axi_rvalid_o && !raddr_q[2] |-> s_axi_rdata_o == 32'h000000ff; endproperty
   a_dir_ones: assert property (p_dir_ones) else $error("direction read not all ones");
   property p_p1_rsvd_read; s_axi_rvalid_o && raddr_q == 4'h4 |-> s_axi_rdata_o[3] && s_axi_rdata_o[31:8] == 24'h0;
   endproperty
   a_p1_rsvd_read: assert property (p_p1_rsvd_read) else $error("port1 bit 3 read wrong");
   property p_p2_rsvd_read; s_axi_rvalid_o && raddr_q == 4'hc |-> s_axi_rdata_o[31:3] == 29'h1f; endproperty
   a_p2_rsvd_read: assert property (p_p2_rsvd_read) else $error("port2 upper bits read wrong");
endmodule
bind tpgio_top tpgio_assertions i_chk (.*);

// >>> sim/tpgio_pins_model.sv
// Model of the external circuit hanging on one general I/O port.
`timescale 1ns/10ps
module tpgio_pins_model (
   input wire [7:0] pin_o_i,
   input wire [7:0] oe_n_i,
   input wire [7:0] ext_i,
   output wire [7:0] level_o
);
   // A released pin takes the outside level, which the bench reshuffles often so a stale value cannot pass.
   assign level_o = (pin_o_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule

// >>> sim/test_two_port_general_io.sv
// Self-checking bench for the two-port general I/O block.
`timescale 1ns/10ps
`include "tpgio_defines.vh"
module test_two_port_general_io;
   logic clock_i = 0;
   logic rstn_i = 0;
   logic [3:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, s_axi_wstrb_i = 0;
   logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_arvalid_i = 0, s_axi_bready_i = 1, s_axi_rready_i = 1;
   logic [31:0] s_axi_wdata_i = 0;
   wire s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   wire [1:0] s_axi_bresp_o, s_axi_rresp_o;
   wire [31:0] s_axi_rdata_o;
   logic [7:0] sel[2], poe[2], po[2], e[2], d[2], v[2], drv, out, ev;
   wire [7:0] pout[2], poen[2], lvl[2];
   logic [7:0] exp_q[$];
   integer seed = 41, err_count = 0, num_checks = 0, i, p;
   always #2.5 clock_i = ~clock_i;
   tpgio_top i_dut (.*, .port1_function_select_i(sel[0]), .port1_periph_out_i(po[0]), .port1_periph_oe_i(poe[0]),
      .port2_function_select_i(sel[1]), .port2_periph_out_i(po[1]), .port2_periph_oe_i(poe[1]),
      .port1_pin_i(lvl[0]), .port1_pin_o(pout[0]), .port1_pin_oe_n_o(poen[0]),
      .port2_pin_i(lvl[1]), .port2_pin_o(pout[1]), .port2_pin_oe_n_o(poen[1]));
   tpgio_pins_model i_pm0 (.pin_o_i(pout[0]), .oe_n_i(poen[0]), .ext_i(e[0]), .level_o(lvl[0]));
   tpgio_pins_model i_pm1 (.pin_o_i(pout[1]), .oe_n_i(poen[1]), .ext_i(e[1]), .level_o(lvl[1]));
   task automatic check(input string n, input [7:0] s, input [7:0] x);
      num_checks++;
      if (s !== x) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", n, x, s);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input [3:0] a, input [7:0] dv, input [3:0] s = 4'hf);
      logic aw, w;
      aw = 0;
      w = 0;
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= {24'h0, dv};
      s_axi_wstrb_i <= s;
      s_axi_awvalid_i <= 1;
      s_axi_wvalid_i <= 1;
      while (!(aw && w)) begin
         @(posedge clock_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 0;
         aw = aw | s_axi_awready_o;
         w = w | s_axi_wready_o;
      end
      while (!s_axi_bvalid_o) @(posedge clock_i);
   endtask
   task automatic rd(input [3:0] a, input [7:0] x);
      exp_q.push_back(x);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1;
      @(posedge clock_i);
      while (!s_axi_arready_o) @(posedge clock_i);
      s_axi_arvalid_i <= 0;
      while (!s_axi_rvalid_o) @(posedge clock_i);
   endtask
   // Each read result is matched against the oldest expectation noted by the driver.
   always @(posedge clock_i) begin
      if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i) check("rdata", s_axi_rdata_o[7:0], exp_q.pop_front());
   end
   // Pins must match the mix of register and peripheral control; data reads still follow direction bits only.
   task chk;
      for (p = 0; p < 2; p++) begin
         drv = (sel[p] & poe[p] | ~sel[p] & d[p]) & (p ? 8'h07 : 8'hf7);
         out = (sel[p] & po[p] | ~sel[p] & v[p]) & drv;
         check(p ? "p2 oe_n" : "p1 oe_n", poen[p], ~drv);
         check(p ? "p2 out" : "p1 out", pout[p] & drv, out);
         ev = (d[p] & v[p] | ~d[p] & (drv & out | ~drv & e[p])) & (p ? 8'h07 : 8'hf7) | (p ? 8'hf8 : 8'h08);
         rd(p ? 4'hc : 4'h4, ev);
      end
      rd(4'h0, 8'hff);
      rd(4'h8, 8'hff);
   endtask
   initial begin
      for (p = 0; p < 2; p++) begin
         sel[p] = 0;
         poe[p] = 0;
         po[p] = 0;
         d[p] = 0;
         v[p] = 0;
         e[p] = $random(seed);
      end
      repeat (10) @(posedge clock_i);
      rstn_i <= 1;
      repeat (3) @(posedge clock_i);
      chk;
      $display("test reset done");
      for (i = 0; i < 12; i++) begin
         for (p = 0; p < 2; p++) begin
            d[p] = $random(seed);
            v[p] = $random(seed);
            sel[p] <= (i < 4) ? 8'h00 : $random(seed);
            poe[p] <= $random(seed);
            po[p] <= $random(seed);
            e[p] <= $random(seed);
         end
         wr(4'h0, d[0]);
         wr(4'h4, v[0]);
         wr(4'h8, d[1]);
         wr(4'hc, v[1]);
         repeat (2) @(posedge clock_i);
         chk;
      end
      $display("test random traffic done");
      // A write without the low byte strobe is answered but must leave the data register alone.
      wr(4'h4, ~v[0], 4'he);
      repeat (2) @(posedge clock_i);
      chk;
      $display("test strobe done");
      finish_test;
   end
   initial begin
      #100000;
      err_count++;
      $display("test watchdog expired");
      finish_test;
   end
endmodule
